// ===== hdl/cef_comparator_ctrl.sv
/*
 Digital control and status logic around two voltage comparators,
 reached over Avalon-MM with waitrequest.
 Assumes comparator results arrive as levels that may be asynchronous;
 the raw pin path is purely combinational so it works with no clock.
*/
`timescale 1ns/1ps

// Notes on behaviour
// RL1 - Writing one to enable bit turns comparator on, zero turns off.
// RL2 - Falling transition of comparator output sets falling-edge flag.
// RL3 - Rising transition of comparator output sets rising-edge flag.
// RL4 - Edge flags stay set until software writes zero to them.
// RL5 - Output state bit reads present comparator result at any time; the code returns the synchronised sample, zero while disabled.
// RL6 - Rising and falling interrupts come from the edge flags.
// RL7 - A disabled comparator drives its pin outputs low.
// RL8 - Two pin outputs: one clocked, one raw that works without clock.
// RL9 - Enabled comparator with output zero raises oscillator wake.
// RL10 - Only comparator zero can act as a reset source.
// RL11 - Two-bit negative hysteresis field in bits one and zero.
// RL12 - Two-bit positive hysteresis field in bits three and two.
// RL13 - Four-bit positive and negative input selects per mux register.
// RL14 - Software clears flags shortly after enabling or retuning.
// RL15 - Response time chosen per comparator in a mode register.
// RL16 - Edges found by comparing consecutive synchronised samples.
module cef_comparator_ctrl
    import cef_pkg::*;
#(
    parameter int NUM_CMP = 2
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Analog comparator cores
    input wire logic [NUM_CMP-1:0] cmp_result,
    output cef_analog_cfg_s [NUM_CMP-1:0] analog_cfg,
    // Pins and system
    output cef_pin_out_s [NUM_CMP-1:0] pin_out,
    output logic [NUM_CMP-1:0] rise_irq,
    output logic [NUM_CMP-1:0] fall_irq,
    output logic irq,
    output logic osc_wake,
    output logic cmp_reset_req
);

    logic [7:0] ctrl_q [NUM_CMP];
    logic [7:0] mux_q [NUM_CMP];
    logic [1:0] mode_q [NUM_CMP];
    logic [NUM_CMP-1:0] sync1_q;
    logic [NUM_CMP-1:0] sync2_q;
    logic [NUM_CMP-1:0] prev_q;
    logic [NUM_CMP-1:0] rise_q;
    logic [NUM_CMP-1:0] fall_q;
    logic [NUM_CMP-1:0] rise_ev;
    logic [NUM_CMP-1:0] fall_ev;
    logic [NUM_CMP-1:0] en;
    logic [NUM_CMP-1:0] latched_q;
    logic rst_en_q;
    logic [3:0] istat_q;
    logic [3:0] imask_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] idx;
    logic req;
    logic wr_go;
    logic rd_go;

    // Index of a register from a byte address.
    function automatic logic [7:0] word_idx(input logic [9:0] a);
        return a[9:2];
    endfunction

    // True when a write strikes the given register index.
    function automatic logic wr_hit(input logic go, input logic [7:0] i,
                                    input logic [7:0] r);
        return go && (i == r);
    endfunction

    assign idx = word_idx(avs_address);
    assign req = avs_read || avs_write;
    // One wait cycle gives a registered read path.
    assign avs_waitrequest = req && !ack_q;
    assign wr_go = avs_write && ack_q && avs_byteenable[0];
    assign rd_go = avs_read && ack_q;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ack_q <= 1'b0;
        else
            ack_q <= req && !ack_q;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++)
        begin : g_cmp
            localparam logic [7:0] CTRL_I = g == 0 ? CEF_CTRL0_IDX
                                                    : CEF_CTRL1_IDX;
            localparam logic [7:0] MUX_I = g == 0 ? CEF_MUX0_IDX
                                                   : CEF_MUX1_IDX;
            localparam logic [7:0] MODE_I = g == 0 ? CEF_MODE0_IDX
                                                    : CEF_MODE1_IDX;

            assign en[g] = ctrl_q[g][CEF_EN_BIT];

            // RL1 RL11 RL12 control write
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    ctrl_q[g] <= CEF_CTRL_RESET;
                else if (wr_hit(wr_go, idx, CTRL_I))
                begin
                    ctrl_q[g][CEF_EN_BIT] <= avs_writedata[CEF_EN_BIT];
                    ctrl_q[g][3:0] <= avs_writedata[3:0];
                end
            end

            // RL13 input mux write
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    mux_q[g] <= CEF_MUX_RESET;
                else if (wr_hit(wr_go, idx, MUX_I))
                    mux_q[g] <= avs_writedata[7:0];
            end

            // RL15 response mode write
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    mode_q[g] <= CEF_MODE_RESET;
                else if (wr_hit(wr_go, idx, MODE_I))
                    mode_q[g] <= avs_writedata[1:0];
            end

            // RL2 RL3 RL4 sticky flags, an edge wins over a clear
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    rise_q[g] <= 1'b0;
                    fall_q[g] <= 1'b0;
                end
                else
                begin
                    if (rise_ev[g])
                        rise_q[g] <= 1'b1;
                    else if (wr_hit(wr_go, idx, CTRL_I) &&
                             !avs_writedata[CEF_RIF_BIT])
                        rise_q[g] <= 1'b0;
                    if (fall_ev[g])
                        fall_q[g] <= 1'b1;
                    else if (wr_hit(wr_go, idx, CTRL_I) &&
                             !avs_writedata[CEF_FIF_BIT])
                        fall_q[g] <= 1'b0;
                end
            end

            assign analog_cfg[g].enable = en[g];
            assign analog_cfg[g].hyst_pos =
                cef_hyst_e'(ctrl_q[g][CEF_HYP_LSB +: 2]);
            assign analog_cfg[g].hyst_neg =
                cef_hyst_e'(ctrl_q[g][CEF_HYN_LSB +: 2]);
            assign analog_cfg[g].pos_sel = mux_q[g][CEF_MUXP_LSB +: 4];
            assign analog_cfg[g].neg_sel = mux_q[g][CEF_MUXN_LSB +: 4];
            assign analog_cfg[g].resp_mode = mode_q[g];

            // RL7 RL8 raw path is clockless and gated low when off
            assign pin_out[g].raw = cmp_result[g] && en[g];
            assign pin_out[g].latched = latched_q[g];
        end
    endgenerate

    // RL16 two-flop synchroniser and sample history
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            sync1_q <= cmp_result & en;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // RL16 one-cycle edge events
    assign rise_ev = sync2_q & ~prev_q;
    assign fall_ev = ~sync2_q & prev_q;

    // RL7 RL8 clocked pin output
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            latched_q <= '0;
        else
            latched_q <= sync2_q & en;
    end

    // RL10 reset source enable, comparator zero only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rst_en_q <= 1'b0;
        else if (wr_hit(wr_go, idx, CEF_RST_IDX))
            rst_en_q <= avs_writedata[0];
    end

    // RL10 reset request
    assign cmp_reset_req = rst_en_q && en[0] && !cmp_result[0];

    // RL9 wake request
    assign osc_wake = |(en & ~cmp_result);

    // RL6 per-edge interrupt lines
    assign rise_irq = rise_q;
    assign fall_irq = fall_q;

    // Sticky status: a read clears only the bits that it returned, so an
    // event landing in the wait state survives; a same-cycle event sets.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            istat_q <= '0;
        else if (rd_go && idx == CEF_IRQ_STAT_IDX)
            istat_q <= (istat_q & ~rdata_q[3:0]) |
                       {fall_ev[1], rise_ev[1], fall_ev[0], rise_ev[0]};
        else
            istat_q <= istat_q |
                       {fall_ev[1], rise_ev[1], fall_ev[0], rise_ev[0]};
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            imask_q <= '0;
        else if (wr_hit(wr_go, idx, CEF_IRQ_MASK_IDX))
            imask_q <= avs_writedata[3:0];
    end

    assign irq = |(istat_q & imask_q);

    // RL5 read mux
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rdata_q <= CEF_UNMAPPED_DATA;
        else if (avs_read && !ack_q)
        begin
            case (idx)
                CEF_CTRL0_IDX:
                    rdata_q <= {24'h000000, en[0], sync2_q[0], rise_q[0],
                                fall_q[0], ctrl_q[0][3:0]};
                CEF_CTRL1_IDX:
                    rdata_q <= {24'h000000, en[1], sync2_q[1], rise_q[1],
                                fall_q[1], ctrl_q[1][3:0]};
                CEF_MUX0_IDX: rdata_q <= {24'h000000, mux_q[0]};
                CEF_MUX1_IDX: rdata_q <= {24'h000000, mux_q[1]};
                CEF_MODE0_IDX: rdata_q <= {30'h0, mode_q[0]};
                CEF_MODE1_IDX: rdata_q <= {30'h0, mode_q[1]};
                CEF_RST_IDX: rdata_q <= {31'h0, rst_en_q};
                CEF_IRQ_STAT_IDX: rdata_q <= {28'h0000000, istat_q};
                CEF_IRQ_MASK_IDX: rdata_q <= {28'h0000000, imask_q};
                default: rdata_q <= CEF_UNMAPPED_DATA;
            endcase
        end
    end

    assign avs_readdata = rdata_q;

    // RL3 rising flag follows an edge
    a_rise_sets: assert property ( // RL3
        @(posedge ref_clk) disable iff (rst)
        (sync2_q[0] && !prev_q[0]) |=> rise_q[0])
        else $error("rising flag not set");
    // RL2 falling flag follows an edge
    a_fall_sets: assert property ( // RL2
        @(posedge ref_clk) disable iff (rst)
        (!sync2_q[0] && prev_q[0]) |=> fall_q[0])
        else $error("falling flag not set");
    // RL4 flag holds without a clearing write
    a_flag_sticky: assert property ( // RL4
        @(posedge ref_clk) disable iff (rst)
        (rise_q[0] && !wr_hit(wr_go, idx, CEF_CTRL0_IDX)) |=> rise_q[0])
        else $error("rising flag dropped");
    // RL1 enable follows write
    a_enable_write: assert property ( // RL1
        @(posedge ref_clk) disable iff (rst)
        wr_hit(wr_go, idx, CEF_CTRL0_IDX) |=>
        en[0] == $past(avs_writedata[CEF_EN_BIT]))
        else $error("enable not written");
    // RL7 raw output low while off
    a_off_low: assert property ( // RL7
        @(posedge ref_clk) disable iff (rst)
        !en[1] |-> !pin_out[1].raw)
        else $error("raw output high while disabled");
    sequence s_high_run;
        (cmp_result[0] && en[0]) [*3];
    endsequence
    // RL8 latched output reaches a steady input
    a_latch_follow: assert property ( // RL8
        @(posedge ref_clk) disable iff (rst)
        s_high_run ##1 (cmp_result[0] && en[0]) |=> pin_out[0].latched)
        else $error("latched output lags");
    // RL9 wake when enabled and low
    a_wake: assert property ( // RL9
        @(posedge ref_clk) disable iff (rst)
        (en[1] && !cmp_result[1]) |-> osc_wake)
        else $error("wake missing");
    // RL10 comparator one never resets
    a_reset_zero: assert property ( // RL10
        @(posedge ref_clk) disable iff (rst)
        cmp_reset_req |-> (en[0] && !cmp_result[0]))
        else $error("reset from wrong source");
    // RL6 rising interrupt line tracks its flag
    a_irq_flag: assert property ( // RL6
        @(posedge ref_clk) disable iff (rst)
        $rose(rise_q[1]) |-> rise_irq[1])
        else $error("interrupt line missing");
    // RL16 edge flag needs a sample change
    a_edge_cause: assert property ( // RL16
        @(posedge ref_clk) disable iff (rst)
        $rose(fall_q[1]) |-> $past(!sync2_q[1] && prev_q[1]))
        else $error("flag without edge");
    // RL6 an edge always lands in the status register
    a_stat_event: assert property ( // RL6
        @(posedge ref_clk) disable iff (rst)
        rise_ev[0] |=> istat_q[0])
        else $error("status event lost");
    // RL13 positive select follows a mux write
    a_mux_write: assert property ( // RL13
        @(posedge ref_clk) disable iff (rst)
        wr_hit(wr_go, idx, CEF_MUX0_IDX) |=>
        analog_cfg[0].pos_sel == $past(avs_writedata[3:0]))
        else $error("input select not written");

endmodule

// ===== hdl/cef_pkg.sv
/*
 Package for the comparator edge flag control block: register offsets,
 field positions, reset values and the bus structs.
 Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
package cef_pkg;

    // Printed offset is not a multiple of four, so it is an index.
    localparam logic [7:0] CEF_CTRL0_IDX = 8'h9B;
    localparam logic [7:0] CEF_MUX0_IDX = 8'h9F;
    localparam logic [7:0] CEF_MODE0_IDX = 8'h9D;
    localparam logic [7:0] CEF_CTRL1_IDX = 8'hA0;
    localparam logic [7:0] CEF_MUX1_IDX = 8'hA1;
    localparam logic [7:0] CEF_MODE1_IDX = 8'hA2;
    localparam logic [7:0] CEF_RST_IDX = 8'hA3;
    localparam logic [7:0] CEF_IRQ_STAT_IDX = 8'hA4;
    localparam logic [7:0] CEF_IRQ_MASK_IDX = 8'hA5;

    localparam int CEF_EN_BIT = 7;
    localparam int CEF_OUT_BIT = 6;
    localparam int CEF_RIF_BIT = 5;
    localparam int CEF_FIF_BIT = 4;
    localparam int CEF_HYP_LSB = 2;
    localparam int CEF_HYN_LSB = 0;
    localparam int CEF_MUXP_LSB = 0;
    localparam int CEF_MUXN_LSB = 4;

    localparam logic [7:0] CEF_CTRL_RESET = 8'h00;
    localparam logic [7:0] CEF_MUX_RESET = 8'hFF;
    localparam logic [1:0] CEF_MODE_RESET = 2'h2;
    localparam logic [31:0] CEF_UNMAPPED_DATA = 32'h00000000;

    typedef enum logic [1:0] {
        CEF_HYST_OFF = 2'h0,
        CEF_HYST_5MV = 2'h1,
        CEF_HYST_10MV = 2'h2,
        CEF_HYST_20MV = 2'h3
    } cef_hyst_e;

    // Per-comparator settings driven to the analog core.
    typedef struct packed {
        logic enable;
        cef_hyst_e hyst_pos;
        cef_hyst_e hyst_neg;
        logic [3:0] pos_sel;
        logic [3:0] neg_sel;
        logic [1:0] resp_mode;
    } cef_analog_cfg_s;

    // Per-comparator pin outputs.
    typedef struct packed {
        logic latched;
        logic raw;
    } cef_pin_out_s;

endpackage

// ===== dv/comparator_edge_flag_control_test.sv
/*
 Self-checking testbench for the comparator edge flag control block.
 Assumes the block answers each Avalon-MM access after one wait state
 and that edges reach the flags three clock edges after the input moves.
*/
`timescale 1ns/1ps

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module comparator_edge_flag_control_test;
    import cef_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] cmp_result = 2'h0;
    cef_analog_cfg_s [1:0] analog_cfg;
    cef_pin_out_s [1:0] pin_out;
    logic [1:0] rise_irq;
    logic [1:0] fall_irq;
    logic irq;
    logic osc_wake;
    logic cmp_reset_req;
    logic [31:0] rd;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    cef_comparator_ctrl #(.NUM_CMP(2)) dut (
        .ref_clk(ref_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmp_result(cmp_result),
        .analog_cfg(analog_cfg), .pin_out(pin_out),
        .rise_irq(rise_irq), .fall_irq(fall_irq), .irq(irq),
        .osc_wake(osc_wake), .cmp_reset_req(cmp_reset_req)
    );

    always #10 ref_clk = ~ref_clk;

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // The ceiling sits far above the under two hundred cycles the tests need.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            final_report();
        end
    end

    // One access: request held until waitrequest is sampled low.
    task automatic bus_access(input logic is_wr, input logic [7:0] idx,
                              input logic [7:0] data);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, data};
        avs_write <= is_wr;
        avs_read <= ~is_wr;
        do
        begin
            @(posedge ref_clk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Outputs launched by the accepting edge are looked at once settled.
        @(negedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        bus_access(1'b1, idx, data);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus_access(1'b0, idx, 8'h00);
        `CHK(rd, {24'h000000, exp})
    endtask

    task automatic set_cmp(input logic [1:0] v);
        @(posedge ref_clk);
        cmp_result <= v;
        repeat (5) @(posedge ref_clk);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(CEF_CTRL0_IDX, CEF_CTRL_RESET);
        rd_chk(CEF_MUX0_IDX, CEF_MUX_RESET);
        rd_chk(CEF_MODE0_IDX, {6'h00, CEF_MODE_RESET});
        rd_chk(CEF_CTRL1_IDX, CEF_CTRL_RESET);
        rd_chk(CEF_MUX1_IDX, CEF_MUX_RESET);
        rd_chk(CEF_IRQ_MASK_IDX, 8'h00);
        rd_chk(8'h10, CEF_UNMAPPED_DATA[7:0]);
        `CHK(pin_out[0].raw, 1'b0)
        `CHK(irq, 1'b0)
        end_test("reset");

        wr(CEF_CTRL0_IDX, 8'h8B);
        `CHK(analog_cfg[0].enable, 1'b1)
        `CHK(analog_cfg[0].hyst_pos, CEF_HYST_10MV)
        `CHK(analog_cfg[0].hyst_neg, CEF_HYST_20MV)
        `CHK(osc_wake, 1'b1)
        rd_chk(CEF_CTRL0_IDX, 8'h8B);
        end_test("enable");

        bus_access(1'b0, CEF_IRQ_STAT_IDX, 8'h00);
        wr(CEF_IRQ_MASK_IDX, 8'h01);
        set_cmp(2'h1);
        `CHK(pin_out[0].raw, 1'b1)
        `CHK(pin_out[0].latched, 1'b1)
        `CHK(rise_irq[0], 1'b1)
        `CHK(irq, 1'b1)
        `CHK(osc_wake, 1'b0)
        rd_chk(CEF_CTRL0_IDX, 8'hEB);
        rd_chk(CEF_IRQ_STAT_IDX, 8'h01);
        `CHK(irq, 1'b0)
        set_cmp(2'h0);
        `CHK(fall_irq[0], 1'b1)
        `CHK(irq, 1'b0)
        rd_chk(CEF_CTRL0_IDX, 8'hBB);
        rd_chk(CEF_IRQ_STAT_IDX, 8'h02);
        end_test("edges");

        set_cmp(2'h1);
        set_cmp(2'h0);
        rd_chk(CEF_CTRL0_IDX, 8'hBB);
        wr(CEF_CTRL0_IDX, 8'h8B);
        rd_chk(CEF_CTRL0_IDX, 8'h8B);
        wr(CEF_CTRL0_IDX, 8'hBB);
        rd_chk(CEF_CTRL0_IDX, 8'h8B);
        `CHK(rise_irq[0], 1'b0)
        end_test("sticky");

        set_cmp(2'h1);
        wr(CEF_CTRL0_IDX, 8'h00);
        repeat (4) @(posedge ref_clk);
        `CHK(pin_out[0].raw, 1'b0)
        `CHK(pin_out[0].latched, 1'b0)
        `CHK(analog_cfg[0].enable, 1'b0)
        end_test("disable");

        set_cmp(2'h0);
        wr(CEF_RST_IDX, 8'h01);
        wr(CEF_CTRL1_IDX, 8'h80);
        `CHK(cmp_reset_req, 1'b0)
        `CHK(osc_wake, 1'b1)
        wr(CEF_IRQ_MASK_IDX, 8'h04);
        bus_access(1'b0, CEF_IRQ_STAT_IDX, 8'h00);
        wr(CEF_CTRL1_IDX, 8'h80);
        set_cmp(2'h2);
        `CHK(pin_out[1].raw, 1'b1)
        `CHK(pin_out[1].latched, 1'b1)
        `CHK(rise_irq[1], 1'b1)
        `CHK(irq, 1'b1)
        rd_chk(CEF_CTRL1_IDX, 8'hE0);
        wr(CEF_CTRL0_IDX, 8'h80);
        `CHK(cmp_reset_req, 1'b1)
        set_cmp(2'h0);
        `CHK(fall_irq[1], 1'b1)
        end_test("second comparator");

        wr(CEF_MUX0_IDX, 8'h5A);
        `CHK(analog_cfg[0].pos_sel, 4'hA)
        `CHK(analog_cfg[0].neg_sel, 4'h5)
        wr(CEF_MUX1_IDX, 8'h3C);
        `CHK(analog_cfg[1].pos_sel, 4'hC)
        `CHK(analog_cfg[1].neg_sel, 4'h3)
        wr(CEF_MODE0_IDX, 8'h01);
        wr(CEF_MODE1_IDX, 8'h03);
        `CHK(analog_cfg[0].resp_mode, 2'h1)
        `CHK(analog_cfg[1].resp_mode, 2'h3)
        rd_chk(CEF_MODE1_IDX, 8'h03);
        @(posedge ref_clk);
        avs_byteenable <= 4'hE;
        wr(CEF_MUX0_IDX, 8'h00);
        @(posedge ref_clk);
        avs_byteenable <= 4'hF;
        rd_chk(CEF_MUX0_IDX, 8'h5A);
        end_test("mux and mode");

        final_report();
    end
endmodule
